/* common/bfag_pkg.sv */
// Constants and carrier types of the boot flash access guard
package bfag_pkg;
  // Flash geometry in 16-bit words
  localparam int AW = 13;
  localparam logic [13:0] FLASH_WORDS = 14'h2000;
  // Boot size: fuse 11 gives the smallest section, each step down doubles it
  localparam logic [13:0] BOOT_MIN = 14'h0100;
  // Fixed halting region start; its size covers the largest boot section
  localparam logic [12:0] HALTING_WRITE_REGION_START = 13'h1800;
  // Lock field bits, 1 = unprogrammed
  localparam int LK_WR = 0;
  localparam int LK_RD = 1;
  localparam logic [1:0] LOCK_FREE = 2'h3;
  localparam logic [3:0] LOCK_RST = 4'hf;
  // Lock register layout
  localparam int LR_APP = 0;
  localparam int LR_BOOT = 2;
  // Register byte offsets
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_LOCK = 4'h4;
  // Status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_ACTIVE = 1;
  localparam int ST_HALT = 2;
  localparam int ST_FUSE = 4;

  typedef enum logic [2:0] {
    OP_FILL = 3'b000,
    OP_ERASE = 3'b001,
    OP_WRITE = 3'b010,
    OP_LOCK = 3'b011,
    OP_RWWEN = 3'b100,
    OP_LOAD = 3'b101
  } bfag_op_t;

  typedef struct packed {
    logic valid;
    bfag_op_t op;
    logic [AW-1:0] addr;
    logic [AW-1:0] pc;
    logic [3:0] lock_data;
  } bfag_req_t;

  typedef struct packed {
    logic halt;
    logic rww_blocked;
    logic irq_suppress;
  } bfag_cpu_t;
endpackage

/* design/bfag_guard.sv */
// Boot flash access guard: section locks, region stall and busy control
// How it works
// - Store ignored unless issued from boot section
// - Boot code may store to any address
// - Boot boundary from fuse; separate section locks
// - Stall choice follows the programmed address
// - Programming fast region keeps CPU running
// - Programming halting region halts CPU throughout
// - Boot section always inside halting region
// - Loads from busy fast region blocked
// - Busy status reads one while blocked
// - Locks only programmed; chip erase clears
// - General write lock ignored for stores
// - General read/write lock ignored for running code
// - App lock 10 blocks app writes
// - App lock 00/01 block boot reads of app
// - App lock read block suppresses app interrupts
// - Boot lock 10 blocks boot writes
// - Boot lock 00/01 block app reads of boot
// - Boot lock read block suppresses boot interrupts
// - Busy set on fast erase/write, cleared later
//
// Implementation choices: the Wishbone slave port and the placing of the registers.
module bfag_guard
  import bfag_pkg::*;
(
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic wb_we_i, // Bus write
  input wire logic [3:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte lanes
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Bus acknowledge
  input wire bfag_req_t req_i, // Store or load request
  output logic permit_o, // Request allowed
  input wire logic prog_done_i, // Erase or write finished
  input wire logic [AW-1:0] exec_pc_i, // Executing word address
  input wire logic ivec_boot_i, // Vectors in boot section
  input wire logic [1:0] boot_size_fuse_i, // Boot size fuse
  input wire logic chip_erase_i, // Full chip erase
  input wire logic ext_lock_we_i, // External lock program
  input wire logic [3:0] ext_lock_i, // External lock data
  output bfag_cpu_t cpu_o // Halt, block, irq mask
);
  logic busy_q;
  logic busy_d;
  logic active_q;
  logic active_d;
  logic halt_q;
  logic halt_d;
  logic irq_q;
  logic irq_d;
  logic ack_q;
  logic [31:0] dat_q;
  logic [31:0] dat_d;
  logic [3:0] lock_q;
  logic [3:0] lock_d;
  logic [1:0] app_lk;
  logic [1:0] boot_lk;
  logic [13:0] boot_start;
  logic pc_boot;
  logic tgt_boot;
  logic tgt_halting_write_region;
  logic ex_boot;
  logic is_prog;
  logic is_load;
  logic wr_blocked;
  logic rd_blocked;
  logic load_ok;
  logic store_ok;
  logic start_prog;
  logic busy_clr;
  logic sw_lock;
  logic wb_hit;
  logic wb_wr_lock;
  logic [31:0] rd_mux;
  logic [3:0] prog_mask;

  assign app_lk = lock_q[LR_APP+:2];
  assign boot_lk = lock_q[LR_BOOT+:2];

  // Largest boot size equals the halting region size
  assign boot_start = FLASH_WORDS - (BOOT_MIN << (~boot_size_fuse_i));
  assign pc_boot = {1'b0, req_i.pc} >= boot_start;
  assign tgt_boot = {1'b0, req_i.addr} >= boot_start;
  assign ex_boot = {1'b0, exec_pc_i} >= boot_start;
  assign tgt_halting_write_region = req_i.addr >= HALTING_WRITE_REGION_START;

  assign is_prog = req_i.op == OP_ERASE || req_i.op == OP_WRITE;
  assign is_load = req_i.op == OP_LOAD;

  // Only the section locks matter; general memory locks never reach here
  assign wr_blocked = tgt_boot ? ~boot_lk[LK_WR] : ~app_lk[LK_WR];
  assign rd_blocked = (pc_boot != tgt_boot) &&
                      (tgt_boot ? ~boot_lk[LK_RD] : ~app_lk[LK_RD]);
  assign load_ok = !rd_blocked && !(busy_q && !tgt_halting_write_region);

  // Page operations serialize: no store is permitted while programming is active
  assign store_ok = pc_boot && !active_q &&
                    !(is_prog && wr_blocked);
  assign permit_o = req_i.valid && (is_load ? load_ok : store_ok);

  assign start_prog = req_i.valid && is_prog && permit_o;
  assign busy_clr = req_i.valid && permit_o &&
                    (req_i.op == OP_RWWEN || req_i.op == OP_FILL);

  // Set wins over clear by construction
  assign busy_d = (start_prog && !tgt_halting_write_region) || (busy_q && !busy_clr);
  assign active_d = start_prog || (active_q && !prog_done_i);
  assign halt_d = (start_prog && tgt_halting_write_region) || (halt_q && !prog_done_i);

  assign irq_d = (!app_lk[LK_RD] && ivec_boot_i && !ex_boot) ||
                 (!boot_lk[LK_RD] && !ivec_boot_i && ex_boot);

  // Locks only move toward programmed; erase restores, program wins
  assign sw_lock = req_i.valid && req_i.op == OP_LOCK && permit_o;
  assign wb_hit = wb_cyc_i && wb_stb_i && !ack_q;
  assign wb_wr_lock = wb_cyc_i && wb_stb_i && wb_we_i && ack_q &&
                      wb_adr_i == REG_LOCK && wb_sel_i[0];
  assign prog_mask = (sw_lock ? req_i.lock_data : LOCK_RST) &
                     (ext_lock_we_i ? ext_lock_i : LOCK_RST) &
                     (wb_wr_lock ? wb_dat_i[3:0] : LOCK_RST);
  assign lock_d = (chip_erase_i ? LOCK_RST : lock_q) & prog_mask;

  assign rd_mux = (wb_adr_i == REG_STATUS) ?
                  {26'h0, boot_size_fuse_i, 1'b0, halt_q, active_q, busy_q} :
                  (wb_adr_i == REG_LOCK) ? {28'h0, lock_q} : 32'h0;
  assign dat_d = wb_hit ? rd_mux : 32'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
      active_q <= 1'b0;
      halt_q <= 1'b0;
      irq_q <= 1'b0;
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      busy_q <= busy_d;
      active_q <= active_d;
      halt_q <= halt_d;
      irq_q <= irq_d;
      ack_q <= wb_hit;
      dat_q <= dat_d;
    end
  end

  // Lock state stands for non-volatile bits; reset loads LOCK_RST only while they are all unknown, otherwise leaves them alone
  always_ff @(posedge clk_i) begin
    if (rst_i && lock_q === 4'hx) begin
      lock_q <= LOCK_RST;
    end else begin
      lock_q <= lock_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign cpu_o.halt = halt_q;
  assign cpu_o.rww_blocked = busy_q;
  assign cpu_o.irq_suppress = irq_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence seq_rww_start;
    start_prog && !tgt_halting_write_region;
  endsequence

  sequence seq_halting_write_region_start;
    start_prog && tgt_halting_write_region;
  endsequence

  chk_store_app: assert property (
    req_i.valid && !is_load && ({1'b0, req_i.pc} < boot_start) |-> !permit_o
  ) else $error("store from application section permitted");

  chk_rww_run: assert property (
    seq_rww_start |=> !cpu_o.halt && cpu_o.rww_blocked
  ) else $error("fast region programming halted cpu or left region open");

  chk_halt_start: assert property (
    seq_halting_write_region_start |=> cpu_o.halt && !cpu_o.rww_blocked
  ) else $error("halting region programming did not halt cpu");

  chk_halt_hold: assert property (
    cpu_o.halt && !prog_done_i |=> cpu_o.halt
  ) else $error("halt dropped before programming finished");

  chk_halt_end: assert property (
    cpu_o.halt && prog_done_i |=> !cpu_o.halt ##1 !cpu_o.halt
  ) else $error("halt stayed after programming finished");

  chk_load_rww: assert property (
    cpu_o.rww_blocked && req_i.valid && is_load &&
    req_i.addr < HALTING_WRITE_REGION_START |-> !permit_o
  ) else $error("load from blocked fast region permitted");

  chk_busy_read: assert property (
    wb_hit && !wb_we_i && wb_adr_i == REG_STATUS |=>
    wb_ack_o && wb_dat_o[ST_BUSY] == $past(busy_q)
  ) else $error("busy status read mismatch");

  chk_busy_clear: assert property (
    busy_q && busy_clr |=> !cpu_o.rww_blocked
  ) else $error("busy not cleared by read enable or fill");

  chk_app_write: assert property (
    req_i.valid && is_prog && !tgt_boot && !lock_q[LR_APP] |-> !permit_o
  ) else $error("app section write permitted under lock");

  chk_boot_write: assert property (
    req_i.valid && is_prog && tgt_boot && !lock_q[LR_BOOT] |-> !permit_o
  ) else $error("boot section write permitted under lock");

  chk_boot_read: assert property (
    req_i.valid && is_load && tgt_boot && !pc_boot &&
    !lock_q[LR_BOOT+1] |-> !permit_o
  ) else $error("app read of locked boot section permitted");

  chk_lock_erase: assert property (
    chip_erase_i && !sw_lock && !ext_lock_we_i && !wb_wr_lock |=>
    lock_q == LOCK_RST
  ) else $error("chip erase did not release locks");

  chk_lock_mono: assert property (
    !chip_erase_i |=> (lock_q & ~$past(lock_q)) == 4'h0
  ) else $error("lock bit returned to unprogrammed without erase");

  chk_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o
  ) else $error("ack held longer than one cycle");

  chk_permit_idle: assert property (
    !req_i.valid |-> !permit_o
  ) else $error("permit without a request");

  chk_store_active: assert property (
    req_i.valid && !is_load && active_q |-> !permit_o
  ) else $error("store permitted while programming active");

  chk_boot_any: assert property (
    req_i.valid && is_prog && pc_boot && !active_q && !wr_blocked |-> permit_o
  ) else $error("boot store to unlocked address refused");

  chk_fuse_small: assert property (
    boot_size_fuse_i == 2'h3 |-> boot_start == FLASH_WORDS - BOOT_MIN
  ) else $error("smallest boot section misplaced");

  chk_fuse_large: assert property (
    boot_size_fuse_i == 2'h0 |-> boot_start == {1'b0, HALTING_WRITE_REGION_START}
  ) else $error("largest boot section misplaced");

  chk_boot_halting_write_region: assert property (
    boot_start >= {1'b0, HALTING_WRITE_REGION_START}
  ) else $error("boot section reaches into fast region");

  chk_busy_hold: assert property (
    busy_q && !busy_clr |=> cpu_o.rww_blocked
  ) else $error("busy dropped without read enable or fill");

  chk_busy_quiet: assert property (
    !busy_q && !(start_prog && !tgt_halting_write_region) |=> !cpu_o.rww_blocked
  ) else $error("busy rose without fast region programming");

  chk_active_set: assert property (
    start_prog |=> active_q
  ) else $error("programming not marked active");

  chk_active_hold: assert property (
    active_q && !prog_done_i |=> active_q
  ) else $error("active dropped before programming finished");

  chk_halt_quiet: assert property (
    !halt_q && !(start_prog && tgt_halting_write_region) |=> !cpu_o.halt
  ) else $error("halt rose without halting region programming");

  chk_load_halting_write_region: assert property (
    busy_q && req_i.valid && is_load && tgt_halting_write_region && !rd_blocked |-> permit_o
  ) else $error("halting region load refused during fast programming");

  chk_app_read: assert property (
    req_i.valid && is_load && !tgt_boot && pc_boot &&
    !lock_q[LR_APP+1] |-> !permit_o
  ) else $error("boot read of locked app section permitted");

  chk_free_load: assert property (
    req_i.valid && is_load && (pc_boot == tgt_boot) &&
    !(busy_q && !tgt_halting_write_region) |-> permit_o
  ) else $error("load within own section refused");

  chk_gen_lock: assert property (
    req_i.valid && is_prog && pc_boot && !active_q && !tgt_boot &&
    app_lk[LK_WR] |-> permit_o
  ) else $error("app store refused with app writes unlocked");

  chk_boot_free: assert property (
    req_i.valid && is_prog && pc_boot && !active_q && tgt_boot &&
    boot_lk[LK_WR] |-> permit_o
  ) else $error("boot store refused with boot writes unlocked");

  chk_app_irq: assert property (
    !lock_q[LR_APP+1] && ivec_boot_i && !ex_boot |=> cpu_o.irq_suppress
  ) else $error("app interrupts not suppressed");

  chk_boot_irq: assert property (
    !lock_q[LR_BOOT+1] && !ivec_boot_i && ex_boot |=> cpu_o.irq_suppress
  ) else $error("boot interrupts not suppressed");

  chk_irq_free: assert property (
    lock_q[LR_APP+1] && lock_q[LR_BOOT+1] |=> !cpu_o.irq_suppress
  ) else $error("interrupts suppressed without read lock");

  chk_ack_follow: assert property (
    wb_hit |=> wb_ack_o
  ) else $error("bus request not acknowledged");

  chk_ack_only: assert property (
    !wb_hit |=> !wb_ack_o
  ) else $error("ack without bus request");

  chk_dat_idle: assert property (
    !wb_ack_o |-> wb_dat_o == 32'h0
  ) else $error("read data shown outside ack");

  chk_lock_write: assert property (
    wb_wr_lock && !chip_erase_i && !sw_lock && !ext_lock_we_i |=>
    lock_q == ($past(lock_q) & $past(wb_dat_i[3:0]))
  ) else $error("lock register write not applied as and");

  chk_fill_clear: assert property (
    busy_q && req_i.valid && req_i.op == OP_FILL && permit_o |=> !busy_q
  ) else $error("fill did not clear busy");

  chk_load_still: assert property (
    req_i.valid && is_load && !active_q |=> !active_q
  ) else $error("load started programming");
endmodule

/* tb/bfag_cpu_model.sv */
// CPU core model issuing store and load requests
module bfag_cpu_model
  import bfag_pkg::*;
(
  input wire logic clk_i, // System clock
  input wire logic permit_i, // Guard decision
  output bfag_req_t req_o // Request to guard
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req_o = '0;
  // One request per call; loads are issued even while the fast region is busy
  task automatic issue(input bfag_op_t op, input logic [AW-1:0] a, input logic [AW-1:0] pc,
                       output logic ok);
    @(posedge clk_i);
    req_o <= '{1'b1, op, a, pc, 4'h0};
    #1 ok = permit_i;
    @(posedge clk_i);
    // Released address, pc and lock fields show no stale value; op keeps its last value
    req_o <= '{1'b0, op, ~a, ~pc, 4'hf};
  endtask
endmodule

/* tb/bfag_guard_tb.sv */
// Self-checking bench for the boot flash access guard
`define CHK(nm, e, a) begin compares++; if ((a) !== (e)) begin n_fail++; \
  $display("ERROR %s exp %0h got %0h", nm, e, a); end end
module bfag_guard_tb;
  import bfag_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, cyc, stb, we, ack, permit, done, erase, ext_we, ivb, ok;
  logic [3:0] adr, ext_lk, sel;
  logic [31:0] wdat, rdat, rd;
  logic [1:0] fuse;
  logic [12:0] xpc;
  logic [13:0] start;
  bfag_req_t req;
  bfag_cpu_t cpu_s;
  int n_fail = 0, compares = 0, cycles = 0;
  bfag_guard bfag_guard_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .req_i(req), .permit_o(permit), .prog_done_i(done), .exec_pc_i(xpc),
    .ivec_boot_i(ivb), .boot_size_fuse_i(fuse), .chip_erase_i(erase),
    .ext_lock_we_i(ext_we), .ext_lock_i(ext_lk), .cpu_o(cpu_s));
  bfag_cpu_model bfag_cpu_model_i (.clk_i(clk_i), .permit_i(permit), .req_o(req));
  initial begin
    clk_i = 0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic test_done;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      test_done;
    end
  end
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    // Ack seen at the edge itself; data and write land on that edge
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = rdat;
    {cyc, stb} <= 2'b00;
  endtask
  // 0 chip erase, 1 programming done, 2 external lock write
  task automatic pulse(input int k);
    @(posedge clk_i);
    if (k == 0) erase <= 1'b1;
    else if (k == 1) done <= 1'b1;
    else ext_we <= 1'b1;
    @(posedge clk_i);
    {erase, done, ext_we} <= 3'b000;
  endtask
  task automatic t_fuse;
    pulse(0);
    for (int f = 0; f < 4; f++) begin
      @(posedge clk_i) fuse <= f[1:0];
      start = 14'h2000 - (14'h0100 << (3 - f));
      bfag_cpu_model_i.issue(OP_FILL, 13'h0, start[12:0], ok);
      `CHK("boot start", 1'b1, ok)
      bfag_cpu_model_i.issue(OP_FILL, 13'h0, start[12:0] - 13'h1, ok);
      `CHK("below start", 1'b0, ok)
      wb(1'b0, REG_STATUS, 32'h0);
      `CHK("fuse field", f[1:0], rd[5:4])
    end
    $display("t_fuse done");
  endtask
  task automatic t_prog;
    bfag_cpu_model_i.issue(OP_ERASE, 13'h0100, 13'h0100, ok);
    `CHK("app store", 1'b0, ok)
    bfag_cpu_model_i.issue(OP_ERASE, 13'h0100, 13'h1f00, ok);
    `CHK("boot store", 1'b1, ok)
    #1 `CHK("fast prog", 2'b10, {cpu_s.rww_blocked, cpu_s.halt})
    bfag_cpu_model_i.issue(OP_LOAD, 13'h0200, 13'h1f00, ok);
    `CHK("busy load", 1'b0, ok)
    wb(1'b0, REG_STATUS, 32'h0);
    `CHK("busy bit", 1'b1, rd[ST_BUSY])
    pulse(1);
    // Busy cleared before fast region code is touched again
    bfag_cpu_model_i.issue(OP_RWWEN, 13'h0, 13'h1f00, ok);
    #1 `CHK("unblock", 1'b0, cpu_s.rww_blocked)
    bfag_cpu_model_i.issue(OP_WRITE, 13'h1f80, 13'h1f00, ok);
    #1 `CHK("halt", 2'b11, {ok, cpu_s.halt})
    pulse(1);
    #1 `CHK("halt end", 1'b0, cpu_s.halt)
    $display("t_prog done");
  endtask
  task automatic t_lock;
    pulse(0);
    sel <= 4'h0;
    wb(1'b1, REG_LOCK, 32'h0);
    sel <= 4'hf;
    wb(1'b0, REG_LOCK, 32'h0);
    `CHK("lane off", 4'hf, rd[3:0])
    wb(1'b1, REG_LOCK, 32'h9);
    ext_lk <= 4'h6;
    pulse(2);
    wb(1'b0, REG_LOCK, 32'h0);
    `CHK("lock and", 4'h0, rd[3:0])
    bfag_cpu_model_i.issue(OP_ERASE, 13'h0100, 13'h1f00, ok);
    `CHK("app wr", 1'b0, ok)
    bfag_cpu_model_i.issue(OP_ERASE, 13'h1f00, 13'h1f00, ok);
    `CHK("boot wr", 1'b0, ok)
    bfag_cpu_model_i.issue(OP_LOAD, 13'h0100, 13'h1f00, ok);
    `CHK("app rd", 1'b0, ok)
    bfag_cpu_model_i.issue(OP_LOAD, 13'h1f00, 13'h0100, ok);
    `CHK("boot rd", 1'b0, ok)
    @(posedge clk_i) {ivb, xpc} <= {1'b1, 13'h0100};
    repeat (2) @(posedge clk_i);
    #1 `CHK("app irq", 1'b1, cpu_s.irq_suppress)
    @(posedge clk_i) {ivb, xpc} <= {1'b0, 13'h1f00};
    repeat (2) @(posedge clk_i);
    #1 `CHK("boot irq", 1'b1, cpu_s.irq_suppress)
    pulse(0);
    wb(1'b0, REG_LOCK, 32'h0);
    `CHK("erased", 4'hf, rd[3:0])
    wb(1'b0, 4'h8, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    $display("t_lock done");
  endtask
  initial begin
    {cyc, stb, we, adr, wdat, done, erase, ext_we, ext_lk, ivb, xpc} = '0;
    rst_i = 1'b1;
    fuse = 2'b11;
    sel = 4'hf;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_fuse;
    t_prog;
    t_lock;
    test_done;
  end
endmodule
